// ### tcc_channel_coder.sv
// Transport packet channel coder: randomiser, RS(204,188), interleaver, link framing
//
// Contract
// - Two link sync characters precede every packet
// - Packet: sync, three header, 184 payload bytes
// - Bits processed MSB first; sync is 47
// - Randomiser is 15 stages, taps 14,15
// - Randomiser reloaded every eight packets
// - First sync of group sent inverted
// - First randomiser bit hits byte after sync
// - Other syncs step randomiser, stay unscrambled
// - Randomiser keeps running without valid input; here it steps only on taken or injected bytes
// - Sixteen parity bytes, 204-byte codeword
// - Sync bytes included in parity calculation
// - Shortened 255,239 code over stated field
// - No convolutional coding, only byte interleaving
// - Twelve cyclic branches, depth 17 times j
// - One-byte cells, selectors move in lockstep
// - Sync bytes take zero-delay branch
// - Sync bytes always enter branch zero
// - Optional 204-byte protected packet structure
// - Idle link words carry sync characters
`timescale 1ns/1ns
`default_nettype none

module tcc_channel_coder
	import tcc_pkg::*;
#(
	parameter int IDLE_LIMIT = IDLE_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Packet source
	input wire logic in_valid_i,
	input wire logic [7:0] in_data_i,
	output logic in_ready_o,
	// Mode and status
	input wire logic mode_204_i,
	output logic locked_o,
	// Link word stream, one word per clock
	output logic [7:0] link_data_o,
	output logic link_k_o
);

	localparam int IDX_W = 8;
	localparam int GRP_W = $clog2(GROUP_PKTS);
	localparam int SEL_W = $clog2(ILV_BRANCHES);
	localparam int IDLE_W = $clog2(IDLE_LIMIT + 1);
	localparam logic [IDX_W-1:0] IDX_LAST_DATA = IDX_W'(PKT_LEN - 1);
	localparam logic [IDX_W-1:0] IDX_LAST_FRAME = IDX_W'(FRAME_LEN - 1);
	localparam logic [GRP_W-1:0] GRP_LAST = GRP_W'(GROUP_PKTS - 1);
	localparam logic [SEL_W-1:0] SEL_LAST = SEL_W'(ILV_BRANCHES - 1);
	localparam logic [IDLE_W-1:0] IDLE_TOP = IDLE_W'(IDLE_LIMIT);

	typedef enum logic [1:0] {
		ST_WAIT,
		ST_LEAD,
		ST_DATA,
		ST_PARITY
	} tcc_state_e;

	// ************************************************************
	// Randomiser step: eight shifts, first output bit to the MSB
	// ************************************************************
	function automatic logic [PRBS_W+7:0] prbs_byte(input logic [PRBS_W-1:0] s);
		logic [PRBS_W-1:0] r;
		logic [7:0] k;
		logic fb;
		r = s;
		k = '0;
		fb = 1'b0;
		for (int b = 7; b >= 0; b--) begin
			fb = r[PRBS_TAP_A] ^ r[PRBS_TAP_B];
			k[b] = fb;
			r = {r[PRBS_W-2:0], fb};
		end
		return {r, k};
	endfunction

	// ************************************************************
	// State
	// ************************************************************
	tcc_state_e state_reg, state_next;
	logic [IDX_W-1:0] idx_reg, idx_next;
	logic [GRP_W-1:0] grp_reg, grp_next;
	logic lead_cnt_reg, lead_cnt_next;
	logic lead_sync_reg, lead_sync_next;
	logic mode_reg, mode_next;
	logic [PRBS_W-1:0] prbs_reg, prbs_next;
	logic [SEL_W-1:0] sel_reg, sel_next;
	logic [IDLE_W-1:0] idle_reg, idle_next;
	logic ready_next;

	// ************************************************************
	// Byte intake decode
	// ************************************************************
	logic in_data_st;
	logic accept;
	logic wait_hit;
	logic inject;
	logic take;
	logic is_sync;
	logic grp_first;
	logic last_data;
	logic [7:0] raw;

	assign in_data_st = (state_reg == ST_DATA);
	assign accept = in_data_st & in_valid_i & in_ready_o;
	assign wait_hit = (state_reg == ST_WAIT) & in_valid_i & in_ready_o &
		(in_data_i == SYNC_BYTE);
	assign inject = in_data_st & ~accept &
		(((idx_reg == '0) & lead_sync_reg) | (idle_reg == IDLE_TOP));
	assign take = accept | inject;
	assign is_sync = (idx_reg == '0);
	assign grp_first = is_sync & (grp_reg == '0);
	assign last_data = (idx_reg == IDX_LAST_DATA);
	// Framing is held by count; a missing sync byte is restored
	assign raw = is_sync ? SYNC_BYTE : (accept ? in_data_i : FILL_BYTE);

	// ************************************************************
	// Randomiser datapath
	// ************************************************************
	logic [PRBS_W+7:0] prbs_step;
	logic [7:0] prbs_key;
	logic [PRBS_W-1:0] prbs_adv;
	logic [7:0] scr;

	assign prbs_step = prbs_byte(prbs_reg);
	assign prbs_key = prbs_step[7:0];
	assign prbs_adv = prbs_step[PRBS_W+7:8];
	assign scr = grp_first ? SYNC_INV : (is_sync ? SYNC_BYTE : (raw ^ prbs_key));

	assign prbs_next = (take & mode_reg) ? (grp_first ? PRBS_INIT : prbs_adv) : prbs_reg;

	// ************************************************************
	// Reed-Solomon parity
	// ************************************************************
	logic rs_feed;
	logic rs_drain;
	logic [7:0] rs_parity;

	assign rs_feed = take & mode_reg;
	assign rs_drain = (state_reg == ST_PARITY);

	tcc_rs_encoder #(
		.NPAR(PAR_LEN)
	) u_rs (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.feed_i(rs_feed),
		.start_i(is_sync),
		.data_i(scr),
		.drain_i(rs_drain),
		.parity_o(rs_parity)
	);

	// ************************************************************
	// Convolutional interleaver
	// ************************************************************
	logic ilv_push;
	logic [7:0] ilv_in;
	logic [SEL_W-1:0] sel_use;
	logic [7:0] br_out [0:ILV_BRANCHES-1];
	logic [7:0] ilv_out;

	assign ilv_push = mode_reg & (take | rs_drain);
	assign ilv_in = rs_drain ? rs_parity : scr;
	assign sel_use = (take & is_sync) ? '0 : sel_reg;
	assign sel_next = ilv_push ? ((sel_use == SEL_LAST) ? '0 : sel_use + 1'b1) : sel_reg;
	assign br_out[0] = ilv_in;
	assign ilv_out = br_out[sel_use];

	genvar j;
	generate
		for (j = 1; j < ILV_BRANCHES; j++) begin : g_branch
			tcc_ilv_branch #(
				.DEPTH(ILV_CELL * j)
			) u_branch (
				.clk_i(clk_i),
				.rst_n_i(rst_n_i),
				.shift_i(ilv_push & (sel_use == SEL_W'(j))),
				.data_i(ilv_in),
				.data_o(br_out[j])
			);
		end
	endgenerate

	// ************************************************************
	// Link word selection
	// ************************************************************
	logic out_valid;
	logic [7:0] out_byte;

	assign out_valid = take | rs_drain;
	assign out_byte = mode_reg ? ilv_out : raw;

	// ************************************************************
	// Sequencing
	// ************************************************************
	// Packet phase, counters and mode latch
	always_comb begin
		state_next = state_reg;
		idx_next = idx_reg;
		grp_next = grp_reg;
		lead_cnt_next = lead_cnt_reg;
		lead_sync_next = lead_sync_reg;
		mode_next = mode_reg;
		unique case (state_reg)
			ST_WAIT: begin
				if (wait_hit) begin
					state_next = ST_LEAD;
					idx_next = '0;
					grp_next = '0;
					lead_cnt_next = 1'b0;
					lead_sync_next = 1'b1;
					mode_next = mode_204_i;
				end
			end
			ST_LEAD: begin
				lead_cnt_next = ~lead_cnt_reg;
				if (lead_cnt_reg == 1'(LEAD_K - 1)) begin
					state_next = ST_DATA;
				end
			end
			ST_DATA: begin
				if (take) begin
					idx_next = idx_reg + 1'b1;
					if (inject & is_sync) begin
						lead_sync_next = 1'b0;
					end
					if (last_data) begin
						if (mode_reg) begin
							state_next = ST_PARITY;
						end else begin
							state_next = ST_LEAD;
							idx_next = '0;
							grp_next = (grp_reg == GRP_LAST) ? '0 : grp_reg + 1'b1;
							lead_cnt_next = 1'b0;
							mode_next = mode_204_i;
						end
					end
				end
			end
			ST_PARITY: begin
				idx_next = idx_reg + 1'b1;
				if (idx_reg == IDX_LAST_FRAME) begin
					state_next = ST_LEAD;
					idx_next = '0;
					grp_next = (grp_reg == GRP_LAST) ? '0 : grp_reg + 1'b1;
					lead_cnt_next = 1'b0;
					mode_next = mode_204_i;
				end
			end
		endcase
	end

	// Starvation timer restarts on every byte taken
	assign idle_next = (in_data_st & ~take & (idle_reg != IDLE_TOP)) ? idle_reg + 1'b1 :
		'0;

	// Source may send while hunting or in the data phase, not for a held sync
	assign ready_next = (state_next == ST_WAIT) |
		((state_next == ST_DATA) & ~((idx_next == '0) & lead_sync_next));

	// Control registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_WAIT;
			idx_reg <= '0;
			grp_reg <= '0;
			lead_cnt_reg <= 1'b0;
			lead_sync_reg <= 1'b0;
			mode_reg <= 1'b0;
			idle_reg <= '0;
		end else begin
			state_reg <= state_next;
			idx_reg <= idx_next;
			grp_reg <= grp_next;
			lead_cnt_reg <= lead_cnt_next;
			lead_sync_reg <= lead_sync_next;
			mode_reg <= mode_next;
			idle_reg <= idle_next;
		end
	end

	// Randomiser state and interleaver selector
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prbs_reg <= PRBS_INIT;
			sel_reg <= '0;
		end else begin
			prbs_reg <= prbs_next;
			sel_reg <= sel_next;
		end
	end

	// Registered outputs
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			in_ready_o <= 1'b0;
			locked_o <= 1'b0;
			link_data_o <= K_SYNC_CODE;
			link_k_o <= 1'b1;
		end else begin
			in_ready_o <= ready_next;
			locked_o <= (state_next != ST_WAIT);
			link_data_o <= out_valid ? out_byte : K_SYNC_CODE;
			link_k_o <= ~out_valid;
		end
	end

endmodule

`default_nettype wire

// ### tcc_pkg.sv
// Shared constants and Galois-field helpers for the transport channel coder
`default_nettype none

package tcc_pkg;

	// ************************************************************
	// Packet and frame geometry
	// ************************************************************
	localparam int PKT_LEN = 188;
	localparam int HDR_LEN = 3;
	localparam int PAY_LEN = 184;
	localparam int PAR_LEN = 16;
	localparam int FRAME_LEN = 204;
	localparam int GROUP_PKTS = 8;
	localparam int LEAD_K = 2;
	localparam logic [7:0] SYNC_BYTE = 8'h47;
	localparam logic [7:0] SYNC_INV = ~SYNC_BYTE;
	localparam logic [7:0] FILL_BYTE = 8'h00;
	localparam logic [7:0] K_SYNC_CODE = 8'hbc;

	// ************************************************************
	// Randomiser: stage 1 sits in bit 0, taps at stages 14 and 15
	// ************************************************************
	localparam int PRBS_W = 15;
	localparam int PRBS_TAP_A = 13;
	localparam int PRBS_TAP_B = 14;
	localparam logic [14:0] PRBS_INIT = 15'h00a9;

	// ************************************************************
	// Reed-Solomon code and field
	// ************************************************************
	localparam int RS_N = 255;
	localparam int RS_K = 239;
	localparam int RS_SHORTEN = 51;
	localparam logic [7:0] GF_POLY = 8'h1d;
	localparam logic [7:0] GF_ALPHA = 8'h02;
	localparam logic [7:0] GF_ONE = 8'h01;

	// ************************************************************
	// Interleaver
	// ************************************************************
	localparam int ILV_BRANCHES = 12;
	localparam int ILV_CELL = FRAME_LEN / ILV_BRANCHES;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int IDLE_TIMEOUT_NS = 100_000;
	localparam int IDLE_CYCLES = IDLE_TIMEOUT_NS / CLK_PERIOD_NS;

	// Field multiply modulo the field polynomial
	function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		logic [7:0] x;
		p = '0;
		x = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) begin
				p = p ^ x;
			end
			x = x[7] ? ({x[6:0], 1'b0} ^ GF_POLY) : {x[6:0], 1'b0};
		end
		return p;
	endfunction

	// Generator polynomial from roots alpha^0..alpha^15, low coefficient first
	function automatic logic [PAR_LEN*8-1:0] rs_gen_poly();
		logic [7:0] g [0:PAR_LEN];
		logic [7:0] root;
		logic [PAR_LEN*8-1:0] packed_g;
		for (int j = 0; j <= PAR_LEN; j++) begin
			g[j] = '0;
		end
		g[0] = GF_ONE;
		root = GF_ONE;
		for (int i = 0; i < PAR_LEN; i++) begin
			for (int j = PAR_LEN; j > 0; j--) begin
				g[j] = g[j-1] ^ gf_mul(g[j], root);
			end
			g[0] = gf_mul(g[0], root);
			root = gf_mul(root, GF_ALPHA);
		end
		packed_g = '0;
		for (int j = 0; j < PAR_LEN; j++) begin
			packed_g[j*8 +: 8] = g[j];
		end
		return packed_g;
	endfunction

endpackage

`default_nettype wire

// ### tcc_rs_encoder.sv
// Systematic Reed-Solomon parity generator, one byte per clock
`timescale 1ns/1ns
`default_nettype none

module tcc_rs_encoder
	import tcc_pkg::*;
#(
	parameter int NPAR = PAR_LEN
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Message side
	input wire logic feed_i,
	input wire logic start_i,
	input wire logic [7:0] data_i,
	// Parity side
	input wire logic drain_i,
	output logic [7:0] parity_o
);

	localparam logic [NPAR*8-1:0] GEN = rs_gen_poly();

	logic [7:0] par_reg [0:NPAR-1];
	logic [7:0] par_next [0:NPAR-1];
	logic [7:0] top;
	logic [7:0] fb;

	// Leading shortening zeros leave a cleared divider untouched, so start
	// simply clears it; the first byte of a codeword is fed with zero state
	assign top = start_i ? 8'h00 : par_reg[NPAR-1];
	assign fb = data_i ^ top;
	assign parity_o = par_reg[NPAR-1];

	// Per-cell divider update or plain shift-out
	genvar i;
	generate
		for (i = 0; i < NPAR; i++) begin : g_cell
			logic [7:0] prev;
			logic [7:0] shin;
			// Lowest cell has no neighbour below, so it takes zero
			if (i == 0) begin : g_first
				assign prev = 8'h00;
				assign shin = 8'h00;
			end else begin : g_rest
				assign prev = start_i ? 8'h00 : par_reg[i-1];
				assign shin = par_reg[i-1];
			end
			assign par_next[i] = feed_i ? (prev ^ gf_mul(fb, GEN[i*8 +: 8])) :
				drain_i ? shin : par_reg[i];
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					par_reg[i] <= 8'h00;
				end else begin
					par_reg[i] <= par_next[i];
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// ### tcc_ilv_branch.sv
// One interleaver branch: a byte-wide shift register of fixed depth
`timescale 1ns/1ns
`default_nettype none

module tcc_ilv_branch #(
	parameter int DEPTH = 17
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Byte stream
	input wire logic shift_i,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o
);

	logic [7:0] cell_reg [0:DEPTH-1];

	// Oldest byte leaves as the new one enters
	assign data_o = cell_reg[DEPTH-1];

	// Cell chain advances only when this branch is selected
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int k = 0; k < DEPTH; k++) begin
				cell_reg[k] <= 8'h00;
			end
		end else if (shift_i) begin
			cell_reg[0] <= data_i;
			for (int k = 1; k < DEPTH; k++) begin
				cell_reg[k] <= cell_reg[k-1];
			end
		end
	end

endmodule

`default_nettype wire

// ### tcc_channel_coder_properties.sv
// Port-level assertions for the transport channel coder
`timescale 1ns/1ns
`default_nettype none

module tcc_channel_coder_properties
	import tcc_pkg::*;
#(
	parameter int IDLE_LIMIT = 20
) (
	// Watched ports
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	input wire logic [7:0] in_data_i,
	input wire logic in_ready_o,
	input wire logic mode_204_i,
	input wire logic locked_o,
	input wire logic [7:0] link_data_o,
	input wire logic link_k_o
);
	int k_run;
	logic take;
	logic sync_in;

	// Byte taken, and taken byte is a sync
	assign take = in_valid_i & in_ready_o;
	assign sync_in = take & (in_data_i == SYNC_BYTE);

	// Run of sync characters once locked
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			k_run <= 0;
		end else begin
			k_run <= (locked_o & link_k_o) ? k_run + 1 : 0;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	property p_reset_out;
		disable iff (1'b0) !rst_n_i |-> !in_ready_o && !locked_o && link_k_o;
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("reset outputs wrong");
	property p_k_code;
		link_k_o |-> link_data_o == K_SYNC_CODE;
	endproperty
	a_k_code: assert property (p_k_code) else $error("sync character code wrong");
	property p_hunt_ready;
		!locked_o && $past(rst_n_i) |-> in_ready_o;
	endproperty
	a_hunt_ready: assert property (p_hunt_ready) else $error("not ready while hunting");
	property p_lock;
		!locked_o && sync_in |=> locked_o;
	endproperty
	a_lock: assert property (p_lock) else $error("no lock on sync");
	property p_no_lock;
		!locked_o && !sync_in |=> !locked_o;
	endproperty
	a_no_lock: assert property (p_no_lock) else $error("lock without sync");
	property p_lock_stays;
		locked_o |=> locked_o;
	endproperty
	a_lock_stays: assert property (p_lock_stays) else $error("lock lost");
	property p_hunt_quiet;
		!locked_o |-> link_k_o;
	endproperty
	a_hunt_quiet: assert property (p_hunt_quiet) else $error("data while hunting");
	property p_answer;
		locked_o && take |-> ##[1:2] !link_k_o;
	endproperty
	a_answer: assert property (p_answer) else $error("taken byte not sent");
	property p_idle_fill;
		k_run < IDLE_LIMIT + 8;
	endproperty
	a_idle_fill: assert property (p_idle_fill) else $error("link idle too long");

	c_lock: cover property ($rose(locked_o));
	c_inv: cover property (!link_k_o && link_data_o == SYNC_INV);
	c_stall: cover property (locked_o && in_ready_o && !in_valid_i);
endmodule

bind tcc_channel_coder tcc_channel_coder_properties #(.IDLE_LIMIT(IDLE_LIMIT))
	tcc_channel_coder_properties_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.in_valid_i(in_valid_i), .in_data_i(in_data_i), .in_ready_o(in_ready_o),
	.mode_204_i(mode_204_i), .locked_o(locked_o), .link_data_o(link_data_o),
	.link_k_o(link_k_o));

`default_nettype wire

// ### tcc_src_model.sv
// Packet source model: bursts or spaced bytes after some junk
`timescale 1ns/1ns
`default_nettype none

module tcc_src_model (
	// Clock and control
	input wire logic clk_i,
	input wire logic start_i,
	input wire logic [3:0] gap_i,
	input wire logic [3:0] junk_i,
	input wire logic [3:0] frames_i,
	// Source port
	input wire logic in_ready_i,
	output logic in_valid_o,
	output logic [7:0] in_data_o
);
	// Byte j of packet f; sync opens each packet
	function automatic logic [7:0] src_byte(input int f, input int j);
		return (j == 0) ? 8'h47 : 8'(f * 37 + j * 3 + 1);
	endfunction

	initial begin
		in_valid_o = 1'b0;
		in_data_o = 8'h00;
	end

	// One stream per start; each byte held until taken
	// burst or gapped
	always @(posedge clk_i) begin
		if (start_i) begin
			send_all();
		end
	end

	task automatic send_all();
		int n;
		int m;
		logic [7:0] b;
		logic rdy;
		n = int'(junk_i) + int'(frames_i) * 188;
		for (int k = 0; k < n; k++) begin
			m = k - int'(junk_i);
			b = (m < 0) ? 8'h10 + 8'(k) : src_byte(m / 188, m % 188);
			#1;
			in_valid_o = 1'b1;
			in_data_o = b;
			do begin
				@(negedge clk_i) rdy = in_ready_i;
				@(posedge clk_i);
			end while (!rdy);
			if (gap_i != 4'h0) begin
				#1;
				in_valid_o = 1'b0;
				in_data_o = ~b;
				repeat (gap_i) @(posedge clk_i);
			end
		end
		#1;
		in_valid_o = 1'b0;
		in_data_o = ~b;
	endtask
endmodule

`default_nettype wire

// ### tcc_channel_coder_tb.sv
// Self-checking bench for the transport channel coder
`timescale 1ns/1ns
`default_nettype none

module tcc_channel_coder_tb
	import tcc_pkg::*;
;
	localparam int IDLE_SIM = 20;
	localparam int CW_N = 4;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b1;
	logic start = 1'b0;
	logic mode = 1'b0;
	logic [3:0] gap = 4'h0;
	logic [3:0] junk = 4'h0;
	logic [3:0] frames = 4'h0;
	logic in_valid;
	logic [7:0] in_data;
	logic in_ready;
	logic locked;
	logic [7:0] link_data;
	logic link_k;
	int fail_count = 0;
	int checked = 0;
	int nw = 0;
	int krun = 0;
	int lim = 0;
	logic [7:0] key_tab [0:GROUP_PKTS*PKT_LEN-2];
	logic [7:0] cw [0:CW_N-1][0:FRAME_LEN-1];

	// 10 MHz clock
	always #50 clk_i = ~clk_i;

	tcc_channel_coder #(.IDLE_LIMIT(IDLE_SIM)) tcc_channel_coder_inst (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .in_valid_i(in_valid), .in_data_i(in_data),
		.in_ready_o(in_ready), .mode_204_i(mode), .locked_o(locked),
		.link_data_o(link_data), .link_k_o(link_k));
	tcc_src_model tcc_src_model_inst (.clk_i(clk_i), .start_i(start), .gap_i(gap),
		.junk_i(junk), .frames_i(frames), .in_ready_i(in_ready),
		.in_valid_o(in_valid), .in_data_o(in_data));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Randomiser key byte n of a group, first bit in the MSB
	initial begin : key_fill
		logic [14:0] r;
		logic fb;
		r = PRBS_INIT;
		for (int n = 0; n < GROUP_PKTS * PKT_LEN - 1; n++) begin
			for (int k = 7; k >= 0; k--) begin
				fb = r[13] ^ r[14];
				r = {r[13:0], fb};
				key_tab[n][k] = fb;
			end
		end
	end

	// Field product, one bit of b at a time from the top
	function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		p = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			p = {p[6:0], 1'b0} ^ (p[7] ? GF_POLY : 8'h00) ^ (b[i] ? a : 8'h00);
		end
		return p;
	endfunction

	// Every recovered codeword must vanish at alpha^0..alpha^15
	task automatic check_codewords();
		logic [7:0] s;
		logic [7:0] a;
		for (int g = 0; g < CW_N; g++) begin
			a = GF_ONE;
			for (int i = 0; i < PAR_LEN; i++) begin
				s = 8'h00;
				for (int j = 0; j < FRAME_LEN; j++) begin
					s = gmul(s, a) ^ cw[g][j];
				end
				check(s, 8'h00);
				a = gmul(a, GF_ALPHA);
			end
		end
	endtask

	// Judge link word number nw of the stream
	task automatic judge(input logic [7:0] w);
		int fl;
		int f;
		int j;
		int g;
		logic [7:0] key;
		fl = mode ? FRAME_LEN : PKT_LEN;
		f = nw / fl;
		j = nw % fl;
		g = mode ? f - j % ILV_BRANCHES : f;
		key = 8'h00;
		if (mode && g >= 0 && j > 0 && j < PKT_LEN) begin
			key = key_tab[(g % GROUP_PKTS) * PKT_LEN + j - 1];
		end
		if (mode && g >= 0 && g < CW_N) begin
			cw[g][j] = w;
		end
		if (j == 0) begin
			check({7'h00, krun >= 2}, 8'h01);
		end
		if (g < 0) begin
			check(w, 8'h00);
		end else if (j == 0 && mode) begin
			check(w, (g % GROUP_PKTS == 0) ? SYNC_INV : SYNC_BYTE);
		end else if (j == 0) begin
			check(w, SYNC_BYTE);
		end else if (!mode) begin
			check(w, tcc_src_model_inst.src_byte(g, j));
		end else if (j < PKT_LEN) begin
			check(w, tcc_src_model_inst.src_byte(g, j) ^ key);
		end
	endtask

	// Output monitor, settled after each edge
	always @(posedge clk_i) begin
		#2;
		if (!rst_n_i) begin
			krun = 0;
		end else if (link_k) begin
			krun++;
		end else begin
			if (nw < lim) begin
				judge(link_data);
			end
			nw++;
			krun = 0;
		end
	end

	task automatic do_reset(input logic m);
		@(posedge clk_i);
		#1;
		rst_n_i = 1'b0;
		mode = m;
		repeat (5) @(posedge clk_i);
		#1;
		rst_n_i = 1'b1;
		nw = 0;
	endtask

	// Start the source, wait for the word count
	task automatic stream(input int words);
		int t;
		lim = words;
		@(posedge clk_i);
		#1;
		start = 1'b1;
		@(posedge clk_i);
		#1;
		start = 1'b0;
		t = 0;
		while (nw < words && t < 20000) begin
			@(posedge clk_i);
			t++;
		end
		check({7'h00, nw >= words}, 8'h01);
	endtask

	// Plain packets, gapped source after junk, then a dry spell
	task automatic test_plain();
		int seen;
		do_reset(1'b0);
		gap = 4'h2;
		junk = 4'h3;
		frames = 4'h3;
		stream(3 * PKT_LEN);
		seen = nw;
		repeat (3 * IDLE_SIM) @(posedge clk_i);
		check({7'h00, nw >= seen + 2}, 8'h01);
		$display("test_plain done");
	endtask

	// Coded burst across a group boundary, long enough to refill every branch
	task automatic test_coded();
		do_reset(1'b1);
		gap = 4'h0;
		junk = 4'h1;
		frames = 4'hf;
		stream(15 * FRAME_LEN);
		check_codewords();
		$display("test_coded done");
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		#1;
		rst_n_i = 1'b0;
		test_plain();
		test_coded();
		conclude();
	end

	// Watchdog far beyond both streams
	initial begin
		#3000000;
		fail_count++;
		conclude();
	end
endmodule

`default_nettype wire
